/* design/tss_pkg.sv */
// Notes on behaviour
// - Each saved entry holds alt level, condition codes, space id, window, processor state.
// - One saved entry per trap level; only the entry at trap_level is accessible.
// - Saved-state access at trap level 0 raises illegal instruction, no access.
// - Entry layout 42:40, 39:32, 31:24, 20:8 state copy, 4:0; 23:21, 7:5 read-only.
// - Trap at level n fills entry n+1; return and access use entry n.
// - Trap-type entry n+1 gets the trap's type; access uses entry n.
// - Trap-type access at level 0 raises illegal instruction; one entry visible.
// - Vector base holds address bits 63:15; low 15 bits read zero, writes dropped.
// - Single processor-state register; a write is seen by the next instruction.
// - Current byte-order bit 1 means little-endian implicit data, 0 big-endian.
// - Instruction fetches are always big-endian.
// - Trap saves old state, copies trap byte-order into current; return restores it.
// - Two-bit memory model: 00 store ordering, 01 reserved, 10/11 implementation choice.
// - Store ordering: loads after loads, stores after loads and stores; loads pass stores.
// - Trap level 0 is normal execution; nonzero means traps in progress.
// - Two trap levels are supported, so two saved and two type entries.
package tss_pkg;

    // Depth and widths
    localparam int MAX_TRAP_DEPTH = 2;
    localparam int TL_W           = 3;
    localparam int PR_ADDR_W      = 5;
    localparam int TS_W           = 43;
    localparam int TT_W           = 9;
    localparam int PS_W           = 13;
    localparam int GL_W           = 3;
    localparam int CCR_W          = 8;
    localparam int ASI_W          = 8;
    localparam int CWP_W          = 5;
    localparam int TBA_LO         = 15;

    // Register indices
    localparam logic [4:0] OFS_SAVED_TRAP_STATE = 5'h02;
    localparam logic [4:0] OFS_SAVED_TRAP_TYPE  = 5'h03;
    localparam logic [4:0] OFS_TRAP_VECTOR_BASE = 5'h05;
    localparam logic [4:0] OFS_PROCESSOR_STATE  = 5'h06;

    // Saved-state field positions
    localparam int TS_GL_LO  = 40;
    localparam int TS_CCR_LO = 32;
    localparam int TS_ASI_LO = 24;
    localparam int TS_PS_LO  = 8;
    localparam int TS_CWP_LO = 0;

    // Processor-state field positions
    localparam int PS_PRIV  = 2;
    localparam int PS_MM_LO = 6;
    localparam int PS_TLE   = 8;
    localparam int PS_CLE   = 9;

    // Memory model encodings
    localparam logic [1:0] MM_TSO  = 2'h0;
    localparam logic [1:0] MM_RSVD = 2'h1;

    // Reset values
    localparam logic [PS_W-1:0]      PSTATE_RST = 13'h0004;
    localparam logic [63-TBA_LO:0]   TBA_RST    = 49'h0;

    typedef enum logic [1:0] {TSS_IDLE, TSS_RD_WAIT} tss_state_e;
    typedef enum logic [1:0] {TSS_CMD_READ, TSS_CMD_RETURN} tss_cmd_e;

    // Trap level selects a real entry
    function automatic logic tss_level_ok(input logic [TL_W-1:0] tl);
        tss_level_ok = (tl != 3'h0) && (tl <= 3'(MAX_TRAP_DEPTH));
    endfunction : tss_level_ok

    // Entry index for trap level n
    function automatic logic tss_idx(input logic [TL_W-1:0] tl);
        tss_idx = tl[0] ^ 1'b1;
    endfunction : tss_idx

    // Clear read-only bits of a saved-state word
    function automatic logic [TS_W-1:0] tss_ts_clean(input logic [63:0] v);
        logic [TS_W-1:0] r;
        r = v[TS_W-1:0];
        r[23:21] = 3'h0;
        r[7:5] = 3'h0;
        tss_ts_clean = r;
    endfunction : tss_ts_clean

endpackage : tss_pkg

/* design/tss_stack_mem.sv */
`timescale 1ns/1ns
module tss_stack_mem #(
    parameter int W     = 8,
    parameter int DEPTH = 2
) (
    // Clock
    input  wire logic         core_clk,
    // Write port
    input  wire logic         wr_en,
    input  wire logic         wr_addr,
    input  wire logic [W-1:0] wr_data,
    // Read port
    input  wire logic         rd_en,
    input  wire logic         rd_addr,
    output logic      [W-1:0] rd_data
);

    logic [W-1:0] mem_reg [DEPTH];
    logic [W-1:0] rd_data_reg;
    logic [W-1:0] rd_data_next;

    // One entry per level
    genvar i;
    for (i = 0; i < DEPTH; i++)
    begin : g_entry
        always_ff @(posedge core_clk)
        begin
            if (wr_en && (wr_addr == 1'(i)))
            begin
                mem_reg[i] <= wr_data;
            end
        end
    end

    always_comb
    begin
        rd_data_next = rd_data_reg;
        if (rd_en)
        begin
            rd_data_next = mem_reg[rd_addr];
        end
    end

    always_ff @(posedge core_clk)
    begin
        rd_data_reg <= rd_data_next;
    end

    assign rd_data = rd_data_reg;

endmodule : tss_stack_mem

/* design/tss_order_ctl.sv */
`timescale 1ns/1ns
module tss_order_ctl (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    // Model select
    input  wire logic [1:0] memory_model,
    // Access about to issue and older ones in flight
    input  wire logic       new_load,
    input  wire logic       new_store,
    input  wire logic       older_load,
    input  wire logic       older_store,
    // Permission
    output logic            issue_ok
);

    logic issue_ok_reg;
    logic issue_ok_next;

    // Unsupported models fall back to store ordering, the strongest one here
    always_comb
    begin
        issue_ok_next = 1'b1;
        case (memory_model)
            tss_pkg::MM_TSO:
            begin
                issue_ok_next = !((new_load && older_load)
                                || (new_store && (older_load || older_store)));
            end
            default:
            begin
                issue_ok_next = !((new_load && older_load)
                                || (new_store && (older_load || older_store)));
            end
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            issue_ok_reg <= 1'b0;
        end
        else
        begin
            issue_ok_reg <= issue_ok_next;
        end
    end

    assign issue_ok = issue_ok_reg;

endmodule : tss_order_ctl

/* design/tss_trap_state_stack.sv */
`timescale 1ns/1ns
module tss_trap_state_stack (
    // Clock and reset
    input  wire logic                       core_clk,
    input  wire logic                       rst_n,
    // Current trap level
    input  wire logic [tss_pkg::TL_W-1:0]   trap_level,
    // Trap entry
    input  wire logic                       trap_req,
    input  wire logic [tss_pkg::TT_W-1:0]   trap_type,
    input  wire logic [tss_pkg::GL_W-1:0]   cur_gl,
    input  wire logic [tss_pkg::CCR_W-1:0]  cur_ccr,
    input  wire logic [tss_pkg::ASI_W-1:0]  cur_asi,
    input  wire logic [tss_pkg::CWP_W-1:0]  cur_cwp,
    // Trap return
    input  wire logic                       return_req,
    output logic                            restore_valid,
    output logic [tss_pkg::GL_W-1:0]        restore_gl,
    output logic [tss_pkg::CCR_W-1:0]       restore_ccr,
    output logic [tss_pkg::ASI_W-1:0]       restore_asi,
    output logic [tss_pkg::CWP_W-1:0]       restore_cwp,
    // Privileged register access
    input  wire logic                       read_priv_reg,
    input  wire logic                       write_priv_reg,
    input  wire logic [tss_pkg::PR_ADDR_W-1:0] pr_addr,
    input  wire logic [63:0]                pr_wdata,
    output logic [63:0]                     pr_rdata,
    output logic                            pr_rvalid,
    output logic                            illegal_instr,
    output logic                            busy,
    // Processor state view
    output logic [63:0]                     trap_vector_base,
    output logic [tss_pkg::PS_W-1:0]        processor_state,
    output logic                            data_little_endian,
    output logic                            fetch_little_endian,
    output logic [1:0]                      memory_model,
    // Access ordering
    input  wire logic                       new_load,
    input  wire logic                       new_store,
    input  wire logic                       older_load,
    input  wire logic                       older_store,
    output logic                            issue_ok
);

    tss_pkg::tss_state_e            state_reg;
    tss_pkg::tss_state_e            state_next;
    tss_pkg::tss_cmd_e              cmd_reg;
    tss_pkg::tss_cmd_e              cmd_next;
    logic [tss_pkg::PR_ADDR_W-1:0]  sel_reg;
    logic [tss_pkg::PR_ADDR_W-1:0]  sel_next;
    logic [tss_pkg::PS_W-1:0]       pstate_reg;
    logic [tss_pkg::PS_W-1:0]       pstate_next;
    logic [63-tss_pkg::TBA_LO:0]    tba_reg;
    logic [63-tss_pkg::TBA_LO:0]    tba_next;
    logic [63:0]                    rdata_reg;
    logic [63:0]                    rdata_next;
    logic                           rvalid_reg;
    logic                           rvalid_next;
    logic                           illegal_reg;
    logic                           illegal_next;
    logic                           busy_reg;
    logic                           rest_valid_reg;
    logic                           rest_valid_next;
    logic [tss_pkg::GL_W-1:0]       rest_gl_reg;
    logic [tss_pkg::GL_W-1:0]       rest_gl_next;
    logic [tss_pkg::CCR_W-1:0]      rest_ccr_reg;
    logic [tss_pkg::CCR_W-1:0]      rest_ccr_next;
    logic [tss_pkg::ASI_W-1:0]      rest_asi_reg;
    logic [tss_pkg::ASI_W-1:0]      rest_asi_next;
    logic [tss_pkg::CWP_W-1:0]      rest_cwp_reg;
    logic [tss_pkg::CWP_W-1:0]      rest_cwp_next;
    logic                           data_le_reg;

    logic                           level_ok;
    logic                           stack_sel;
    logic                           ts_wr_en;
    logic                           tt_wr_en;
    logic                           wr_addr;
    logic [tss_pkg::TS_W-1:0]       ts_wdata;
    logic [tss_pkg::TT_W-1:0]       tt_wdata;
    logic                           rd_en;
    logic [tss_pkg::TS_W-1:0]       ts_rdata;
    logic [tss_pkg::TT_W-1:0]       tt_rdata;

    assign level_ok  = tss_pkg::tss_level_ok(trap_level);
    assign stack_sel = (pr_addr == tss_pkg::OFS_SAVED_TRAP_STATE)
                     || (pr_addr == tss_pkg::OFS_SAVED_TRAP_TYPE);

    // Stack write port: trap fills level n+1, privileged write hits level n
    always_comb
    begin
        ts_wr_en = 1'b0;
        tt_wr_en = 1'b0;
        wr_addr  = tss_pkg::tss_idx(trap_level);
        ts_wdata = tss_pkg::tss_ts_clean(pr_wdata);
        tt_wdata = pr_wdata[tss_pkg::TT_W-1:0];
        if (!busy_reg && trap_req)
        begin
            if (trap_level < 3'(tss_pkg::MAX_TRAP_DEPTH))
            begin
                ts_wr_en = 1'b1;
                tt_wr_en = 1'b1;
                wr_addr  = trap_level[0];
                ts_wdata = {cur_gl, cur_ccr, cur_asi, 3'h0, pstate_reg,
                            3'h0, cur_cwp};
                tt_wdata = trap_type;
            end
        end
        else if (!busy_reg && !return_req && !read_priv_reg && write_priv_reg && level_ok)
        begin
            ts_wr_en = (pr_addr == tss_pkg::OFS_SAVED_TRAP_STATE);
            tt_wr_en = (pr_addr == tss_pkg::OFS_SAVED_TRAP_TYPE);
        end
    end

    assign rd_en = (state_reg == tss_pkg::TSS_IDLE) && (state_next == tss_pkg::TSS_RD_WAIT);

    tss_stack_mem #(
        .W     (tss_pkg::TS_W),
        .DEPTH (tss_pkg::MAX_TRAP_DEPTH)
    ) u_state_mem (
        .core_clk (core_clk),
        .wr_en    (ts_wr_en),
        .wr_addr  (wr_addr),
        .wr_data  (ts_wdata),
        .rd_en    (rd_en),
        .rd_addr  (tss_pkg::tss_idx(trap_level)),
        .rd_data  (ts_rdata)
    );

    tss_stack_mem #(
        .W     (tss_pkg::TT_W),
        .DEPTH (tss_pkg::MAX_TRAP_DEPTH)
    ) u_type_mem (
        .core_clk (core_clk),
        .wr_en    (tt_wr_en),
        .wr_addr  (wr_addr),
        .wr_data  (tt_wdata),
        .rd_en    (rd_en),
        .rd_addr  (tss_pkg::tss_idx(trap_level)),
        .rd_data  (tt_rdata)
    );

    // Command sequencing, processor state and answers
    always_comb
    begin
        state_next      = state_reg;
        cmd_next        = cmd_reg;
        sel_next        = sel_reg;
        pstate_next     = pstate_reg;
        tba_next        = tba_reg;
        rdata_next      = rdata_reg;
        rvalid_next     = 1'b0;
        illegal_next    = 1'b0;
        rest_valid_next = 1'b0;
        rest_gl_next    = rest_gl_reg;
        rest_ccr_next   = rest_ccr_reg;
        rest_asi_next   = rest_asi_reg;
        rest_cwp_next   = rest_cwp_reg;
        case (state_reg)
            tss_pkg::TSS_IDLE:
            begin
                if (trap_req)
                begin
                    pstate_next[tss_pkg::PS_CLE] = pstate_reg[tss_pkg::PS_TLE];
                end
                else if (return_req)
                begin
                    if (level_ok)
                    begin
                        state_next = tss_pkg::TSS_RD_WAIT;
                        cmd_next   = tss_pkg::TSS_CMD_RETURN;
                    end
                    else
                    begin
                        illegal_next = 1'b1;
                    end
                end
                else if (read_priv_reg || write_priv_reg)
                begin
                    if (stack_sel && !level_ok)
                    begin
                        illegal_next = 1'b1;
                    end
                    else if (read_priv_reg)
                    begin
                        state_next = tss_pkg::TSS_RD_WAIT;
                        cmd_next   = tss_pkg::TSS_CMD_READ;
                        sel_next   = pr_addr;
                    end
                    else if (pr_addr == tss_pkg::OFS_TRAP_VECTOR_BASE)
                    begin
                        tba_next = pr_wdata[63:tss_pkg::TBA_LO];
                    end
                    else if (pr_addr == tss_pkg::OFS_PROCESSOR_STATE)
                    begin
                        pstate_next = pr_wdata[tss_pkg::PS_W-1:0];
                    end
                end
            end
            tss_pkg::TSS_RD_WAIT:
            begin
                state_next = tss_pkg::TSS_IDLE;
                if (cmd_reg == tss_pkg::TSS_CMD_RETURN)
                begin
                    rest_valid_next = 1'b1;
                    rest_gl_next    = ts_rdata[tss_pkg::TS_GL_LO +: tss_pkg::GL_W];
                    rest_ccr_next   = ts_rdata[tss_pkg::TS_CCR_LO +: tss_pkg::CCR_W];
                    rest_asi_next   = ts_rdata[tss_pkg::TS_ASI_LO +: tss_pkg::ASI_W];
                    rest_cwp_next   = ts_rdata[tss_pkg::TS_CWP_LO +: tss_pkg::CWP_W];
                    pstate_next     = ts_rdata[tss_pkg::TS_PS_LO +: tss_pkg::PS_W];
                end
                else
                begin
                    rvalid_next = 1'b1;
                    case (sel_reg)
                        tss_pkg::OFS_SAVED_TRAP_STATE: rdata_next = {21'h0, ts_rdata};
                        tss_pkg::OFS_SAVED_TRAP_TYPE:  rdata_next = {55'h0, tt_rdata};
                        tss_pkg::OFS_TRAP_VECTOR_BASE: rdata_next = {tba_reg, 15'h0};
                        tss_pkg::OFS_PROCESSOR_STATE:  rdata_next = {51'h0, pstate_reg};
                        default:                       rdata_next = 64'h0;
                    endcase
                end
            end
            default:
            begin
                state_next = tss_pkg::TSS_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            state_reg      <= tss_pkg::TSS_IDLE;
            cmd_reg        <= tss_pkg::TSS_CMD_READ;
            sel_reg        <= 5'h0;
            pstate_reg     <= tss_pkg::PSTATE_RST;
            tba_reg        <= tss_pkg::TBA_RST;
            rdata_reg      <= 64'h0;
            rvalid_reg     <= 1'b0;
            illegal_reg    <= 1'b0;
            busy_reg       <= 1'b0;
            rest_valid_reg <= 1'b0;
            rest_gl_reg    <= 3'h0;
            rest_ccr_reg   <= 8'h0;
            rest_asi_reg   <= 8'h0;
            rest_cwp_reg   <= 5'h0;
            data_le_reg    <= 1'b0;
        end
        else
        begin
            state_reg      <= state_next;
            cmd_reg        <= cmd_next;
            sel_reg        <= sel_next;
            pstate_reg     <= pstate_next;
            tba_reg        <= tba_next;
            rdata_reg      <= rdata_next;
            rvalid_reg     <= rvalid_next;
            illegal_reg    <= illegal_next;
            busy_reg       <= (state_next != tss_pkg::TSS_IDLE);
            rest_valid_reg <= rest_valid_next;
            rest_gl_reg    <= rest_gl_next;
            rest_ccr_reg   <= rest_ccr_next;
            rest_asi_reg   <= rest_asi_next;
            rest_cwp_reg   <= rest_cwp_next;
            data_le_reg    <= pstate_next[tss_pkg::PS_CLE];
        end
    end

    tss_order_ctl u_order (
        .core_clk     (core_clk),
        .rst_n        (rst_n),
        .memory_model (pstate_reg[tss_pkg::PS_MM_LO +: 2]),
        .new_load     (new_load),
        .new_store    (new_store),
        .older_load   (older_load),
        .older_store  (older_store),
        .issue_ok     (issue_ok)
    );

    assign restore_valid       = rest_valid_reg;
    assign restore_gl          = rest_gl_reg;
    assign restore_ccr         = rest_ccr_reg;
    assign restore_asi         = rest_asi_reg;
    assign restore_cwp         = rest_cwp_reg;
    assign pr_rdata            = rdata_reg;
    assign pr_rvalid           = rvalid_reg;
    assign illegal_instr       = illegal_reg;
    assign busy                = busy_reg;
    assign trap_vector_base    = {tba_reg, 15'h0};
    assign processor_state     = pstate_reg;
    assign data_little_endian  = data_le_reg;
    assign fetch_little_endian = 1'b0;
    assign memory_model        = pstate_reg[tss_pkg::PS_MM_LO +: 2];

endmodule : tss_trap_state_stack

/* verification/tss_pipe_model.sv */
`timescale 1ns/1ns
module tss_pipe_model (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    // Trap traffic seen
    input  wire logic       trap_req,
    input  wire logic       restore_valid,
    input  wire logic       busy,
    // Level held for the block
    output logic      [2:0] trap_level
);
    logic [2:0] lvl_reg;
    logic [2:0] lvl_next;

    // Level 0 is normal running; a trap climbs one level up to two
    always_comb
    begin
        lvl_next = lvl_reg;
        if (trap_req && !busy && lvl_reg < 3'h2)
            lvl_next = lvl_reg + 3'h1;
        else if (restore_valid && lvl_reg != 3'h0)
            lvl_next = lvl_reg - 3'h1;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            lvl_reg <= 3'h0;
        else
            lvl_reg <= lvl_next;
    end

    assign trap_level = lvl_reg;
endmodule : tss_pipe_model

/* verification/tss_chk_props.sv */
`timescale 1ns/1ns
module tss_chk_props (
    // Clock and reset
    input wire logic                         core_clk,
    input wire logic                         rst_n,
    // Requests
    input wire logic [tss_pkg::TL_W-1:0]     trap_level,
    input wire logic                         trap_req,
    input wire logic                         return_req,
    input wire logic                         read_priv_reg,
    input wire logic                         write_priv_reg,
    input wire logic [tss_pkg::PR_ADDR_W-1:0] pr_addr,
    input wire logic [63:0]                  pr_wdata,
    // Answers
    input wire logic                         pr_rvalid,
    input wire logic                         illegal_instr,
    input wire logic                         busy,
    input wire logic [63:0]                  trap_vector_base,
    input wire logic [tss_pkg::PS_W-1:0]     processor_state,
    input wire logic                         data_little_endian,
    input wire logic                         fetch_little_endian,
    input wire logic [1:0]                   memory_model,
    // Ordering
    input wire logic                         new_load,
    input wire logic                         new_store,
    input wire logic                         older_load,
    input wire logic                         older_store,
    input wire logic                         issue_ok
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    logic        rd_go;
    logic        wr_go;
    logic        lvl0;
    logic        tle;
    logic        hold;
    logic [12:0] wd13;
    assign rd_go = read_priv_reg && !busy && !trap_req && !return_req;
    assign wr_go = write_priv_reg && !busy && !trap_req && !return_req && !read_priv_reg;
    assign lvl0  = trap_level == 3'h0;
    assign tle   = processor_state[tss_pkg::PS_TLE];
    assign wd13  = pr_wdata[12:0];
    assign hold  = new_load && older_load || new_store && (older_load || older_store);

    property p_rd_lat;
        rd_go && !lvl0 && pr_addr == 5'h02 |=> busy && !pr_rvalid ##1 pr_rvalid && !busy;
    endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read late");
    property p_ill_ts;
        (rd_go || wr_go) && lvl0 && pr_addr == 5'h02 |=> illegal_instr ##1 !pr_rvalid;
    endproperty
    a_ill_ts: assert property (p_ill_ts) else $error("state not refused");
    property p_ill_tt;
        (rd_go || wr_go) && lvl0 && pr_addr == 5'h03 |=> illegal_instr ##1 !pr_rvalid;
    endproperty
    a_ill_tt: assert property (p_ill_tt) else $error("type not refused");
    property p_tba_low;
        trap_vector_base[14:0] == 15'h0;
    endproperty
    a_tba_low: assert property (p_tba_low) else $error("vector base low bits");
    property p_ps_wr;
        wr_go && pr_addr == 5'h06 |=> processor_state == $past(wd13);
    endproperty
    a_ps_wr: assert property (p_ps_wr) else $error("state write slow");
    property p_cle;
        data_little_endian == processor_state[tss_pkg::PS_CLE];
    endproperty
    a_cle: assert property (p_cle) else $error("data byte order");
    property p_fetch;
        !fetch_little_endian;
    endproperty
    a_fetch: assert property (p_fetch) else $error("fetch byte order");
    property p_trap_cle;
        trap_req && !busy |=> data_little_endian == $past(tle);
    endproperty
    a_trap_cle: assert property (p_trap_cle) else $error("trap byte order");
    property p_mm;
        memory_model == processor_state[7:6];
    endproperty
    a_mm: assert property (p_mm) else $error("model field");
    property p_tso;
        $past(rst_n) |-> issue_ok == !$past(hold);
    endproperty
    a_tso: assert property (p_tso) else $error("store ordering");

    c_read: cover property (rd_go && !lvl0 ##2 pr_rvalid);
    c_ill: cover property (illegal_instr);
    c_trap: cover property (trap_req && !busy && tle);
endmodule : tss_chk_props

bind tss_trap_state_stack tss_chk_props u_chk (.*);

/* verification/tss_trap_state_stack_tb.sv */
`timescale 1ns/1ns
`define CHK(nm, e, s) begin checks++; if ((s) !== (e)) begin err_total++; \
    $display("BAD %s exp %h got %h", nm, e, s); end end
module tss_trap_state_stack_tb;
    logic        core_clk       = 1'b0;
    logic        rst_n          = 1'b0;
    logic        trap_req       = 1'b0;
    logic [8:0]  trap_type      = 9'h0;
    logic [2:0]  cur_gl         = 3'h0;
    logic [7:0]  cur_ccr        = 8'h0;
    logic [7:0]  cur_asi        = 8'h0;
    logic [4:0]  cur_cwp        = 5'h0;
    logic        return_req     = 1'b0;
    logic        read_priv_reg  = 1'b0;
    logic        write_priv_reg = 1'b0;
    logic [4:0]  pr_addr        = 5'h0;
    logic [63:0] pr_wdata       = 64'h0;
    logic [3:0]  ord            = 4'h0;
    logic        new_load, new_store, older_load, older_store;
    logic [2:0]  trap_level, restore_gl;
    logic [7:0]  restore_ccr, restore_asi;
    logic [4:0]  restore_cwp;
    logic        restore_valid, pr_rvalid, illegal_instr, busy, issue_ok;
    logic        data_little_endian, fetch_little_endian;
    logic [63:0] pr_rdata, trap_vector_base, rd;
    logic [12:0] processor_state;
    logic [1:0]  memory_model;
    logic        ill, rv;
    int          err_total = 0;
    int          checks    = 0;
    typedef struct {logic [4:0] a; logic [63:0] d; logic [63:0] e; logic bad;} tss_row_s;
    tss_row_s    rows [5] = '{'{5'h05, '1, 64'hffff_ffff_ffff_8000, 1'b0},
                              '{5'h06, 64'h344, 64'h344, 1'b0},
                              '{5'h02, 64'h1, 64'h0, 1'b1},
                              '{5'h03, 64'h1, 64'h0, 1'b1},
                              '{5'h1f, 64'h1234, 64'h0, 1'b0}};

    assign {new_load, new_store, older_load, older_store} = ord;
    tss_trap_state_stack dut (.*);
    tss_pipe_model u_pipe (.core_clk(core_clk), .rst_n(rst_n), .trap_req(trap_req),
        .restore_valid(restore_valid), .busy(busy), .trap_level(trap_level));

    always #2 core_clk = ~core_clk;

    task automatic conclude;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude

    task automatic acc(input logic w, input logic [4:0] a, input logic [63:0] d);
        @(posedge core_clk);
        read_priv_reg  <= ~w;
        write_priv_reg <= w;
        pr_addr        <= a;
        pr_wdata       <= d;
        @(posedge core_clk);
        read_priv_reg  <= 1'b0;
        write_priv_reg <= 1'b0;
        #1 ill = illegal_instr;
        @(posedge core_clk);
        #1 rv = pr_rvalid;
        rd = pr_rdata;
    endtask : acc

    task automatic trap(input logic [8:0] t, input logic [2:0] g, input logic [7:0] c,
                        input logic [7:0] s, input logic [4:0] w);
        @(posedge core_clk);
        trap_req  <= 1'b1;
        trap_type <= t;
        cur_gl    <= g;
        cur_ccr   <= c;
        cur_asi   <= s;
        cur_cwp   <= w;
        @(posedge core_clk);
        trap_req  <= 1'b0;
        #1;
    endtask : trap

    task automatic ret;
        @(posedge core_clk);
        return_req <= 1'b1;
        @(posedge core_clk);
        return_req <= 1'b0;
        #1 ill = illegal_instr;
        @(posedge core_clk);
        #1 rv = restore_valid;
    endtask : ret

    initial
    begin
        repeat (3000) @(posedge core_clk);
        err_total++;
        conclude();
    end

    initial
    begin
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        #1 `CHK("tba_rst", 64'h0, trap_vector_base)
        `CHK("ps_rst", 13'h0004, processor_state)
        $display("test reset done");
        foreach (rows[i])
        begin
            acc(1'b1, rows[i].a, rows[i].d);
            `CHK("wr_ill", rows[i].bad, ill)
            acc(1'b0, rows[i].a, 64'h0);
            `CHK("rd_ill", rows[i].bad, ill)
            `CHK("rd_valid", ~rows[i].bad, rv)
            if (!rows[i].bad) `CHK("rd_data", rows[i].e, rd)
        end
        `CHK("ps_rows", 13'h0344, processor_state)
        $display("test rows done");
        for (int m = 3; m >= 0; m--)
        begin
            acc(1'b1, 5'h06, 64'h104 | (64'(m) << 6));
            `CHK("mm", 2'(m), memory_model)
            `CHK("cle", 1'b0, data_little_endian)
            `CHK("fetch", 1'b0, fetch_little_endian)
            for (int k = 0; k < 16; k++)
            begin
                @(posedge core_clk);
                ord <= 4'(k);
                @(posedge core_clk);
                #1 `CHK("issue", ~(k[3] & k[1] | k[2] & (k[1] | k[0])), issue_ok)
            end
        end
        $display("test model done");
        trap(9'h1a5, 3'h5, 8'hc3, 8'h81, 5'h1b);
        `CHK("cle_trap", 1'b1, data_little_endian)
        acc(1'b0, 5'h02, 64'h0);
        `CHK("ts1", {21'h0, 3'h5, 8'hc3, 8'h81, 3'h0, 13'h0104, 3'h0, 5'h1b}, rd)
        acc(1'b0, 5'h03, 64'h0);
        `CHK("tt1", 64'h1a5, rd)
        trap(9'h0f2, 3'h2, 8'h3c, 8'h14, 5'h04);
        acc(1'b0, 5'h02, 64'h0);
        `CHK("ts2", {21'h0, 3'h2, 8'h3c, 8'h14, 3'h0, 13'h0304, 3'h0, 5'h04}, rd)
        acc(1'b0, 5'h03, 64'h0);
        `CHK("tt2", 64'h0f2, rd)
        acc(1'b1, 5'h02, '1);
        acc(1'b0, 5'h02, 64'h0);
        `CHK("ts_rsvd", 64'h0000_07ff_ff1f_ff1f, rd)
        acc(1'b1, 5'h02, 64'h0000_0254_9a00_0412);
        ret();
        `CHK("ret_v", 1'b1, rv)
        `CHK("ret2", {3'h2, 8'h54, 8'h9a, 5'h12}, {restore_gl, restore_ccr, restore_asi, restore_cwp})
        `CHK("ret2_ps", 13'h0004, processor_state)
        ret();
        `CHK("ret1", {3'h5, 8'hc3, 8'h81, 5'h1b}, {restore_gl, restore_ccr, restore_asi, restore_cwp})
        `CHK("ret1_ps", 13'h0104, processor_state)
        ret();
        `CHK("ret0_ill", 1'b1, ill)
        `CHK("ret0_nv", 1'b0, rv)
        $display("test trap done");
        conclude();
    end
endmodule : tss_trap_state_stack_tb
